// ==== rtl/urpce_map.vh ====
// Register offsets, field positions and reset values of the port status block
// Assumes inclusion by the port logic only; definitions only
`ifndef URPCE_MAP_VH
`define URPCE_MAP_VH
`define URPCE_AW 4
`define URPCE_DW 16
`define URPCE_OFF_PORTSC 4'h0
`define URPCE_OFF_IRQ_STAT 4'h4
`define URPCE_OFF_IRQ_MASK 4'h8
`define URPCE_BIT_CONN 0
`define URPCE_BIT_CONN_CHG 1
`define URPCE_BIT_EN 2
`define URPCE_BIT_EN_CHG 3
`define URPCE_BIT_RSVD7 7
`define URPCE_IRQ_CONN 0
`define URPCE_IRQ_EN 1
`define URPCE_IRQ_W 2
`define URPCE_RST_IRQ 2'h0
`define URPCE_RD_ZERO 16'h0000
`endif

// ==== rtl/urpce_port.v ====
// Root-hub port enable and connect status bits with register port and interrupt
// Assumes a plain strobe bus on ref_clk_i; attach and fault inputs may be async
`timescale 1ns/100ps
`default_nettype none
`include "urpce_map.vh"
// What this block does
// - Port enables only by software writing one
// - Disconnect, fault or software zero disables port
// - Enable bit follows actual port state only
// - Software enable change waits for transaction end
// - Connect change flag set on every change
// - Further changes keep flag set, uncounted
// - Writing one clears connect change flag
// - Pending connect change reported only once
// - Connect status shows present attachment state
// - Enable change set by disconnect or fault disable
module urpce_port (
  // Clock and reset
  input wire ref_clk_i,
  input wire rstn_i,
  // Register port
  input wire [`URPCE_AW-1:0] addr_i,
  input wire [`URPCE_DW-1:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [`URPCE_DW-1:0] rdata_o,
  // Port link
  input wire attach_i,
  input wire fault_i,
  input wire busy_i,
  output reg port_en_o,
  // Status change endpoint poll
  input wire poll_i,
  output reg poll_chg_o,
  // Interrupt
  output reg irq_o
);
  ////////////////////////////////////////////////////////////////
  wire attach_s;
  wire fault_s;
  urpce_sync u_sync_att (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .d_i(attach_i),
    .q_o(attach_s)
  );
  urpce_sync u_sync_flt (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .d_i(fault_i),
    .q_o(fault_s)
  );
  ////////////////////////////////////////////////////////////////
  reg conn;
  reg conn_chg;
  reg en;
  reg en_chg;
  reg req_pend;
  reg req_val;
  reg reported;
  reg [`URPCE_IRQ_W-1:0] irq_stat;
  reg [`URPCE_IRQ_W-1:0] irq_mask;
  wire wr_sc = wr_i && (addr_i == `URPCE_OFF_PORTSC);
  wire wr_is = wr_i && (addr_i == `URPCE_OFF_IRQ_STAT);
  wire wr_im = wr_i && (addr_i == `URPCE_OFF_IRQ_MASK);
  wire disc = conn && !attach_s;
  wire conn_ev = conn != attach_s;
  wire fault_dis = en && (disc || fault_s);
  wire [`URPCE_IRQ_W-1:0] ev = {fault_dis, conn_ev};
  reg next_en;
  reg next_conn_chg;
  reg [`URPCE_IRQ_W-1:0] next_irq_stat;
  ////////////////////////////////////////////////////////////////
  always @* begin
    next_en = en;
    if (req_pend && !busy_i) begin
      next_en = req_val;
    end
    if (fault_dis) begin
      next_en = 1'b0;
    end
    next_conn_chg = conn_chg;
    if (wr_sc && wdata_i[`URPCE_BIT_CONN_CHG]) begin
      next_conn_chg = 1'b0;
    end
    if (conn_ev) begin
      next_conn_chg = 1'b1;
    end
    next_irq_stat = (irq_stat & ~(wr_is ? wdata_i[`URPCE_IRQ_W-1:0] : `URPCE_RST_IRQ)) | ev;
  end
  ////////////////////////////////////////////////////////////////
  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      conn <= 1'b0;
      conn_chg <= 1'b0;
      en <= 1'b0;
      en_chg <= 1'b0;
      req_pend <= 1'b0;
      req_val <= 1'b0;
      reported <= 1'b0;
      irq_stat <= `URPCE_RST_IRQ;
      irq_mask <= `URPCE_RST_IRQ;
      rdata_o <= `URPCE_RD_ZERO;
      port_en_o <= 1'b0;
      poll_chg_o <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      conn <= attach_s;
      conn_chg <= next_conn_chg;
      en <= next_en;
      port_en_o <= next_en;
      if (fault_dis) begin
        req_pend <= 1'b0;
      end else if (wr_sc && (wdata_i[`URPCE_BIT_EN] != en)) begin
        req_pend <= 1'b1;
        req_val <= wdata_i[`URPCE_BIT_EN];
      end else if (req_pend && !busy_i) begin
        req_pend <= 1'b0;
      end
      if (fault_dis) begin
        en_chg <= 1'b1;
      end else if (wr_sc && wdata_i[`URPCE_BIT_EN_CHG]) begin
        en_chg <= 1'b0;
      end
      poll_chg_o <= poll_i && conn_chg && !reported;
      if (conn_ev || !next_conn_chg) begin
        reported <= 1'b0;
      end else if (poll_i && conn_chg) begin
        reported <= 1'b1;
      end
      irq_stat <= next_irq_stat;
      if (wr_im) begin
        irq_mask <= wdata_i[`URPCE_IRQ_W-1:0];
      end
      irq_o <= |(next_irq_stat & (wr_im ? wdata_i[`URPCE_IRQ_W-1:0] : irq_mask));
      rdata_o <= `URPCE_RD_ZERO;
      if (rd_i) begin
        case (addr_i)
          `URPCE_OFF_PORTSC: begin
            rdata_o[`URPCE_BIT_CONN] <= conn;
            rdata_o[`URPCE_BIT_CONN_CHG] <= conn_chg;
            rdata_o[`URPCE_BIT_EN] <= en;
            rdata_o[`URPCE_BIT_EN_CHG] <= en_chg;
            rdata_o[`URPCE_BIT_RSVD7] <= 1'b1;
          end
          `URPCE_OFF_IRQ_STAT: begin
            rdata_o[`URPCE_IRQ_W-1:0] <= irq_stat;
          end
          `URPCE_OFF_IRQ_MASK: begin
            rdata_o[`URPCE_IRQ_W-1:0] <= irq_mask;
          end
          default: begin
            rdata_o <= `URPCE_RD_ZERO;
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ==== rtl/urpce_sync.v ====
// Two-flop synchroniser for one asynchronous level
// Assumes d_i comes from outside the ref_clk_i domain
`timescale 1ns/100ps
`default_nettype none
module urpce_sync (
  // Clock and reset
  input wire ref_clk_i,
  input wire rstn_i,
  // Level
  input wire d_i,
  output reg q_o
);
  reg meta;
  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta <= 1'b0;
      q_o <= 1'b0;
    end else begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule
`default_nettype wire

// ==== testbench/testbench.sv ====
// Port block bench
// Assumes urpce_port, urpce_dev, checker
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic ref_clk_i = 0, rstn_i = 0, wr_i = 0, rd_i = 0, busy_i = 0, fault_i = 0, poll_i = 0, plug = 0;
  logic [3:0] addr_i = 0;
  logic [15:0] wdata_i = 0, rdata_o, got;
  wire attach_i, port_en_o, poll_chg_o, irq_o;
  integer err_count = 0, checks_done = 0, conn = 0, chg = 0, en = 0, ech = 0, seed = 32'hd904936a;
  urpce_port dut (.*);
  urpce_dev dev (.plug_i(plug), .attach_o(attach_i));
  initial forever #4 ref_clk_i = ~ref_clk_i;
  task chk(input logic [15:0] s, e); begin
    checks_done++;
    if (s !== e) begin
      err_count++;
      $display("BAD %0t got %h exp %h", $time, s, e);
    end
  end endtask
  task cyc(input integer n); repeat (n) @(posedge ref_clk_i); endtask
  task wr(input logic [3:0] a, input logic [15:0] d); begin
    @(posedge ref_clk_i); addr_i <= a; wdata_i <= d; wr_i <= 1;
    @(posedge ref_clk_i); wr_i <= 0;
  end endtask
  task rd(input logic [3:0] a, input logic [15:0] e); begin
    @(posedge ref_clk_i); addr_i <= a; rd_i <= 1;
    @(posedge ref_clk_i); rd_i <= 0;
    #1 chk(rdata_o, e);
  end endtask
  task poll(input logic e); begin
    @(posedge ref_clk_i); poll_i <= 1;
    @(posedge ref_clk_i); poll_i <= 0;
    #1 chk(poll_chg_o, e);
  end endtask
  function logic [15:0] psc; psc = {12'h008, ech[0], en[0], chg[0], conn[0]}; endfunction
  task stop_test; begin
    $display("errors %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  end endtask
  initial begin #200000; err_count++; stop_test; end
  initial begin
    cyc(3); rstn_i <= 1;
    rd(0, psc());
    wr(4'hC, 16'hFFFF); rd(4'hC, 0);
    wr(0, 16'h0004); cyc(1); en = 1; #1 chk(port_en_o, 1);
    plug = 1; cyc(6); conn = 1; chg = 1; rd(0, psc());
    poll(1); poll(0);
    plug = 0; cyc(6); plug = 1; cyc(6); en = 0; ech = 1; rd(0, psc());
    poll(1);
    wr(0, 16'h000A); chg = 0; ech = 0; rd(0, psc());
    wr(4, 16'h0003); rd(4, 0);
    busy_i <= 1; wr(0, 16'h0004); cyc(3); busy_i <= 0; #1 chk(port_en_o, 0);
    cyc(1); #1 chk(port_en_o, 1); en = 1;
    wr(8, 16'h0002); fault_i <= 1; cyc(5); #1 chk(port_en_o, 0);
    chk(irq_o, 1); fault_i <= 0; en = 0; ech = 1; rd(0, psc());
    wr(4, 16'h0002); #1 chk(irq_o, 0);
    wr(0, 16'h000C); en = 1; ech = 0; wr(0, 0); en = 0; rd(0, psc());
    repeat (4) begin
      got = $random(seed); wr(8, got); rd(8, got & 16'h0003);
    end
    stop_test;
  end
endmodule
`default_nettype wire

// ==== testbench/urpce_dev.sv ====
// Attached device: plug state reaches the wire after a skew
// Assumes the bench sets plug_i
`timescale 1ns/100ps
`default_nettype none
module urpce_dev (
  input wire logic plug_i,
  output logic attach_o
);
  initial attach_o = 1'b0;
  always @(plug_i) attach_o <= #3 plug_i;
endmodule
`default_nettype wire

// ==== testbench/urpce_props.sv ====
// Port block checker
// Assumes bind to urpce_port
`timescale 1ns/100ps
`default_nettype none
module urpce_props (
  input wire ref_clk_i, rstn_i, wr_i, rd_i, attach_i, fault_i, busy_i, poll_i,
  input wire port_en_o, poll_chg_o, irq_o,
  input wire [3:0] addr_i,
  input wire [15:0] wdata_i, rdata_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  wire sw_on = wr_i && addr_i == 4'h0 && wdata_i[2];
  reg asked;
  always @(posedge ref_clk_i or negedge rstn_i)
    if (!rstn_i) asked <= 1'b0;
    else if (wr_i && addr_i == 4'h0) asked <= wdata_i[2];
  en_cause_a: assert property ($rose(port_en_o) |-> asked) else $error("en cause");
  en_time_a: assert property (sw_on && !busy_i && !port_en_o && attach_i && $past(attach_i, 3)
    && !fault_i && !$past(fault_i, 3) |=> ##1 port_en_o) else $error("en late");
  busy_hold_a: assert property (busy_i && !port_en_o |=> !port_en_o) else $error("busy");
  fault_off_a: assert property ($rose(fault_i) |-> ##[1:4] !port_en_o) else $error("fault");
  unplug_off_a: assert property ($fell(attach_i) |-> ##[1:4] !port_en_o) else $error("unplug");
  poll_once_a: assert property (poll_chg_o ##1 poll_i |=> !poll_chg_o) else $error("poll");
  read_fmt_a: assert property (rd_i && addr_i == 4'h0 |=> rdata_o[7] && rdata_o[15:8] == 8'h00
    && rdata_o[2] == $past(port_en_o)) else $error("fmt");
  read_pulse_a: assert property (!$past(rd_i) |-> rdata_o == 16'h0000) else $error("rdata");
endmodule
bind urpce_port urpce_props chk (.*);
`default_nettype wire
